// ### verilog/banked_logical_device_config.sv
module banked_logical_device_config
    import cfg_bank_pkg::*;
(
    // clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_b_i,
    // strap
    input  wire logic                  base_address_strap_i,
    // host i/o port
    input  wire io_req_t               io_req_i,
    output logic [7:0]                 rdata_o,
    output logic                       rvalid_o,
    // unit configuration outputs
    output bank_regs_t [num_banks-1:0] bank_cfg_o,
    output logic [num_globals*8-1:0]   global_cfg_o
);
    // ****************************************
    // strap capture
    // ****************************************
    logic       strap_s1_q, strap_s2_q, strap_q, strap_done_q;
    logic       strap_d, strap_done_d;
    logic       settle_a_q, settle_a_d, settle_b_q, settle_b_d;

    // follow the synchroniser until it holds the pin, then freeze it
    always_comb begin
        settle_a_d   = 1'b1;
        settle_b_d   = settle_a_q;
        strap_d      = strap_done_q ? strap_q : strap_s2_q;
        strap_done_d = settle_b_q;
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_s1_q   <= 1'b0;
            strap_s2_q   <= 1'b0;
            strap_q      <= 1'b0;
            strap_done_q <= 1'b0;
            settle_a_q   <= 1'b0;
            settle_b_q   <= 1'b0;
        end else begin
            strap_s1_q   <= base_address_strap_i;
            strap_s2_q   <= strap_s1_q;
            strap_q      <= strap_d;
            strap_done_q <= strap_done_d;
            settle_a_q   <= settle_a_d;
            settle_b_q   <= settle_b_d;
        end
    end

    // ****************************************
    // decode
    // ****************************************
    logic [15:0] base;
    logic        hit_index, hit_data, bank_ok, banked, global_hit;
    logic [7:0]  index_q, index_d, bank_q, bank_d;
    logic [3:0]  bank_sel;

    always_comb begin
        base       = strap_q ? base_strap1 : base_strap0;
        hit_index  = io_req_i.addr == base;
        hit_data   = io_req_i.addr == base + 16'h0001;
        bank_ok    = bank_q <= bank_max;
        bank_sel   = bank_q[3:0];
        banked     = (index_q >= idx_banked_min) && bank_ok;
        global_hit = (index_q >= idx_global_lo) && (index_q <= idx_global_hi);
    end

    // ****************************************
    // index, bank select and globals
    // ****************************************
    logic [num_globals*8-1:0] glob_q, glob_d;

    always_comb begin
        index_d = index_q;
        bank_d  = bank_q;
        glob_d  = glob_q;
        if (io_req_i.wr && hit_index) begin
            index_d = io_req_i.wdata;
        end
        if (io_req_i.wr && hit_data) begin
            if (index_q == idx_bank_select) begin
                bank_d = io_req_i.wdata;
            end
            if (global_hit) begin
                glob_d[index_q[3:0]*8 +: 8] = io_req_i.wdata;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            index_q <= reset_value;
            bank_q  <= reset_value;
            glob_q  <= '0;
        end else begin
            index_q <= index_d;
            bank_q  <= bank_d;
            glob_q  <= glob_d;
        end
    end

    // ****************************************
    // banked registers
    // ****************************************
    bank_regs_t [num_banks-1:0] bank_q_r, bank_d_r;

    always_comb begin
        bank_d_r = bank_q_r;
        if (io_req_i.wr && hit_data && banked) begin
            unique case (index_q)
                idx_activate: begin
                    bank_d_r[bank_sel].activate = io_req_i.wdata & activate_mask;
                end
                idx_base0_high: bank_d_r[bank_sel].base0_high = io_req_i.wdata;
                idx_base0_low:  bank_d_r[bank_sel].base0_low  = io_req_i.wdata;
                idx_base1_high: bank_d_r[bank_sel].base1_high = io_req_i.wdata;
                idx_base1_low:  bank_d_r[bank_sel].base1_low  = io_req_i.wdata;
                idx_irq_select: begin
                    bank_d_r[bank_sel].irq_select = io_req_i.wdata & irq_select_mask;
                end
                idx_irq_type: begin
                    if (irq_type_writable[bank_sel]) begin
                        bank_d_r[bank_sel].irq_type = io_req_i.wdata & irq_type_mask;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bank_q_r <= '0;
        end else begin
            bank_q_r <= bank_d_r;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] rdata_d;
    logic       rvalid_d;
    bank_regs_t cur;

    always_comb begin
        cur      = bank_q_r[bank_sel];
        rdata_d  = unimpl_value;
        rvalid_d = io_req_i.rd && (hit_index || hit_data);
        if (hit_index) begin
            rdata_d = index_q;
        end else if (index_q == idx_bank_select) begin
            rdata_d = bank_q;
        end else if (global_hit) begin
            rdata_d = glob_q[index_q[3:0]*8 +: 8];
        end else if (index_q == idx_dma0 || index_q == idx_dma1) begin
            rdata_d = no_dma_value;
        end else if (banked) begin
            unique case (index_q)
                idx_activate:   rdata_d = cur.activate;
                idx_base0_high: rdata_d = cur.base0_high;
                idx_base0_low:  rdata_d = cur.base0_low;
                idx_base1_high: rdata_d = cur.base1_high;
                idx_base1_low:  rdata_d = cur.base1_low;
                idx_irq_select: rdata_d = cur.irq_select;
                idx_irq_type:   rdata_d = cur.irq_type;
                default:        rdata_d = unimpl_value;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o      <= '0;
            rvalid_o     <= 1'b0;
            bank_cfg_o   <= '0;
            global_cfg_o <= '0;
        end else begin
            rdata_o      <= rdata_d;
            rvalid_o     <= rvalid_d;
            bank_cfg_o   <= bank_d_r;
            global_cfg_o <= glob_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_index_write;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.wr && hit_index) |=> index_q == $past(io_req_i.wdata);
    endproperty
    a_index_write: assert property (p_index_write) else $error("index not stored");

    property p_bank_write;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.wr && hit_data && index_q == idx_bank_select)
            |=> bank_q == $past(io_req_i.wdata);
    endproperty
    a_bank_write: assert property (p_bank_write) else $error("bank select not stored");

    property p_dma_read;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.rd && hit_data && (index_q == idx_dma0 || index_q == idx_dma1))
            |=> rdata_o == no_dma_value;
    endproperty
    a_dma_read: assert property (p_dma_read) else $error("dma default wrong");

    property p_reserved_bank;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.wr && hit_data && !bank_ok) |=> $stable(bank_q_r);
    endproperty
    a_reserved_bank: assert property (p_reserved_bank) else $error("bank regs changed");

    property p_act_bits;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.rd && hit_data && banked && index_q == idx_activate) |=> rdata_o[7:1] == 7'h00;
    endproperty
    a_act_bits: assert property (p_act_bits) else $error("activate reserved bits set");

    property p_type_bits;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.rd && hit_data && banked && index_q == idx_irq_type) |=> rdata_o[7:2] == 6'h00;
    endproperty
    a_type_bits: assert property (p_type_bits) else $error("type reserved bits set");

    property p_wake_clear;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.wr && hit_data && banked && index_q == idx_irq_select
            && !io_req_i.wdata[wake_bit])
            |=> !bank_q_r[$past(bank_sel)].irq_select[wake_bit];
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake bit not cleared");

    property p_rvalid;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.rd && (hit_index || hit_data)) |=> rvalid_o;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");

    // antecedents shared by the read and write checks below
    sequence s_index_read;
        io_req_i.rd && hit_index;
    endsequence

    sequence s_global_read;
        io_req_i.rd && hit_data && global_hit;
    endsequence

    sequence s_low_read;
        io_req_i.rd && hit_data && index_q < idx_global_lo && index_q != idx_bank_select;
    endsequence

    sequence s_low_write;
        io_req_i.wr && hit_data && index_q < idx_global_lo && index_q != idx_bank_select;
    endsequence

    sequence s_reserved_read;
        io_req_i.rd && hit_data && !bank_ok && index_q >= idx_banked_min
            && index_q != idx_dma0 && index_q != idx_dma1;
    endsequence

    property p_index_read;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_index_read |=> rdata_o == $past(index_q);
    endproperty
    a_index_read: assert property (p_index_read) else $error("index read wrong");

    property p_global_read;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_global_read |=> rdata_o == $past(glob_q[index_q[3:0]*8 +: 8]);
    endproperty
    a_global_read: assert property (p_global_read) else $error("global read wrong");

    property p_low_read;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_low_read |=> rdata_o == unimpl_value;
    endproperty
    a_low_read: assert property (p_low_read) else $error("unimplemented read wrong");

    property p_low_write;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_low_write |=> $stable(bank_q_r) && $stable(glob_q) && $stable(bank_q);
    endproperty
    a_low_write: assert property (p_low_write) else $error("stray write landed");

    property p_reserved_read;
        @(posedge clock_i) disable iff (!rst_b_i)
        s_reserved_read |=> rdata_o == unimpl_value;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("bank read wrong");

    property p_global_apart;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.wr && hit_data && global_hit) |=> $stable(bank_q_r) && $stable(bank_q);
    endproperty
    a_global_apart: assert property (p_global_apart) else $error("global write leaked");

    property p_base_write;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.wr && hit_data && banked && index_q == idx_base1_low)
            |=> bank_q_r[$past(bank_sel)].base1_low == $past(io_req_i.wdata);
    endproperty
    a_base_write: assert property (p_base_write) else $error("base byte not stored");

    property p_stray_read;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.rd && !hit_index && !hit_data) |=> !rvalid_o;
    endproperty
    a_stray_read: assert property (p_stray_read) else $error("stray read answered");

    property p_strap_hold;
        @(posedge clock_i) disable iff (!rst_b_i)
        strap_done_q |=> $stable(strap_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");

    property p_select_bits;
        @(posedge clock_i) disable iff (!rst_b_i)
        (io_req_i.rd && hit_data && banked && index_q == idx_irq_select)
            |=> rdata_o[7:5] == 3'h0;
    endproperty
    a_select_bits: assert property (p_select_bits) else $error("select bits set");
endmodule

// ### verilog/cfg_bank_pkg.sv
package cfg_bank_pkg;
    // ****************************************
    // address map
    // ****************************************
    localparam logic [15:0] base_strap0     = 16'h002e;
    localparam logic [15:0] base_strap1     = 16'h004e;
    localparam logic [7:0]  idx_bank_select = 8'h07;
    localparam logic [7:0]  idx_global_lo   = 8'h20;
    localparam logic [7:0]  idx_global_hi   = 8'h2f;
    localparam logic [7:0]  idx_banked_min  = 8'h30;
    localparam logic [7:0]  idx_activate    = 8'h30;
    localparam logic [7:0]  idx_base0_high  = 8'h60;
    localparam logic [7:0]  idx_base0_low   = 8'h61;
    localparam logic [7:0]  idx_base1_high  = 8'h62;
    localparam logic [7:0]  idx_base1_low   = 8'h63;
    localparam logic [7:0]  idx_irq_select  = 8'h70;
    localparam logic [7:0]  idx_irq_type    = 8'h71;
    localparam logic [7:0]  idx_dma0        = 8'h74;
    localparam logic [7:0]  idx_dma1        = 8'h75;
    localparam int          num_banks       = 11;
    localparam logic [7:0]  bank_max        = 8'h0a;
    localparam int          num_globals     = 16;
    // ****************************************
    // field positions and defaults
    // ****************************************
    localparam int          activate_bit    = 0;
    localparam int          wake_bit        = 4;
    localparam int          polarity_bit    = 1;
    localparam int          type_bit        = 0;
    localparam logic [7:0]  irq_select_mask = 8'h1f;
    localparam logic [7:0]  irq_type_mask   = 8'h03;
    localparam logic [7:0]  activate_mask   = 8'h01;
    localparam logic [7:0]  unimpl_value    = 8'h00;
    localparam logic [7:0]  no_dma_value    = 8'h04;
    localparam logic [7:0]  reset_value     = 8'h00;
    // per-unit: does the type register accept writes (1) or stay fixed
    localparam logic [10:0] irq_type_writable = 11'h7ff;

    // unit numbering in bank order
    typedef enum logic [7:0] {
        floppy_unit, parallel_unit, serial_unit_two_infrared, serial_unit_one,
        wakeup_unit, mouse_unit, keyboard_mouse_unit, gpio_unit,
        two_wire_bus_unit, fan_control_unit, watchdog_unit
    } bank_number_t;

    // one bank of unit settings
    typedef struct packed {
        logic [7:0] activate;
        logic [7:0] base0_high;
        logic [7:0] base0_low;
        logic [7:0] base1_high;
        logic [7:0] base1_low;
        logic [7:0] irq_select;
        logic [7:0] irq_type;
    } bank_regs_t;

    // host i/o cycle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } io_req_t;
endpackage

// ### tb/io_host_model.sv
module io_host_model
    import cfg_bank_pkg::*;
(
    // clock
    input  wire logic       clock_i,
    // answer from the device
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    // request towards the device
    output io_req_t         io_req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial io_req_o = '0;

    // one write cycle; released fields show inverted values
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1 io_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock_i);
        #1 io_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // one read cycle; answer taken one edge after the request edge
    task automatic get(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge clock_i);
        #1 io_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock_i);
        #1 io_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        d = rdata_i;
        v = rvalid_i;
    endtask
endmodule

// ### tb/banked_logical_device_config_bench.sv
`define chk(got, want) begin check_count++; if ((got) !== (want)) begin error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, want); end end
module banked_logical_device_config_bench;
    import cfg_bank_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals and reference model state
    // ****************************************
    logic                       clock_i = 1'b0;
    logic                       rst_b_i = 1'b0;
    logic                       strap   = 1'b0;
    io_req_t                    io_req;
    logic [7:0]                 rdata;
    logic                       rvalid;
    bank_regs_t [num_banks-1:0] bank_cfg;
    logic [num_globals*8-1:0]   global_cfg;
    logic [31:0]                sel;
    integer                     seed = 32'h2b171681;
    int error_cnt = 0, check_count = 0, cycles = 0;
    int r[num_banks][256];
    int g[16];
    int bank = 0, idx = 0, base = 0;
    int pick[13] = '{'h07, 'h20, 'h2f, 'h30, 'h60, 'h61, 'h62, 'h63, 'h70, 'h71, 'h74, 'h75, 'hf0};
    int bidx[7] = '{'h30, 'h60, 'h61, 'h62, 'h63, 'h70, 'h71};

    // instances
    banked_logical_device_config uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .base_address_strap_i(strap), .io_req_i(io_req), .rdata_o(rdata),
        .rvalid_o(rvalid), .bank_cfg_o(bank_cfg), .global_cfg_o(global_cfg));
    io_host_model host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .io_req_o(io_req));

    // clock and hang guard
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 10000) begin
            error_cnt++;
            complete_run();
        end
    end

    // writable bits of each banked register, zero when unimplemented
    function automatic int mask(int i);
        case (i)
            'h30: return 'h01;
            'h60, 'h61, 'h62, 'h63: return 'hff;
            'h70: return 'h1f;
            'h71: return 'h03;
            default: return 0;
        endcase
    endfunction

    // value a data port read should give
    function automatic int expect_data();
        if (idx == 'h07) return bank;
        if (idx >= 'h20 && idx <= 'h2f) return g[idx - 'h20];
        if (idx == 'h74 || idx == 'h75) return 'h04;
        if (idx >= 'h30 && bank < num_banks) return r[bank][idx];
        return 0;
    endfunction

    // ****************************************
    // access tasks
    // ****************************************
    task automatic index_write(input int i);
        host.put(16'(base), 8'(i));
        idx = i;
    endtask

    task automatic data_write(input int d);
        host.put(16'(base + 1), 8'(d));
        if (idx == 'h07) bank = d;
        else if (idx >= 'h20 && idx <= 'h2f) g[idx - 'h20] = d;
        else if (idx >= 'h30 && bank < num_banks) r[bank][idx] = d & mask(idx);
    endtask

    task automatic port_read(input int off, input int want);
        logic [7:0] d;
        logic       v;
        host.get(16'(base + off), d, v);
        `chk(v, 1'b1)
        `chk(d, 8'(want))
    endtask

    task automatic check_outputs();
        logic [55:0] e;
        for (int b = 0; b < num_banks; b++) begin
            e = '0;
            foreach (bidx[k]) e = {e[47:0], 8'(r[b][bidx[k]])};
            `chk(bank_cfg[b], e)
        end
        for (int n = 0; n < 16; n++) `chk(global_cfg[n*8 +: 8], 8'(g[n]))
    endtask

    // clear the reference model as a reset does
    task automatic model_reset();
        bank = 0;
        idx = 0;
        foreach (g[n]) g[n] = 0;
        foreach (r[b, i]) r[b][i] = 0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [7:0] d;
        logic       v;
        strap = 1'($random(seed));
        base = strap ? 'h4e : 'h2e;
        repeat (5) @(posedge clock_i);
        #1 rst_b_i = 1'b1;
        repeat (3) @(posedge clock_i);
        port_read(0, 0);
        check_outputs();
        $display("test reset done");
        // bank codes 0 to 15, reserved ones 11 to 15 too
        for (int b = 0; b < 16; b++) begin
            index_write('h07);
            data_write(b);
            port_read(1, b);
            index_write('h30);
            data_write('hff);
            port_read(1, expect_data());
            check_outputs();
        end
        $display("test bank walk done");
        // random mix of index, data and readback accesses
        repeat (500) begin
            sel = $random(seed);
            case (sel[1:0])
                2'd0: index_write(sel[2] ? pick[sel[7:4] % 13] : int'(sel[15:8]));
                2'd1: data_write(sel[3] ? int'(sel[23:20]) : int'(sel[23:16]));
                2'd2: port_read(1, expect_data());
                2'd3: port_read(0, idx);
            endcase
            check_outputs();
        end
        $display("test random done");
        // second reset in mid-run with the other strap level
        @(posedge clock_i);
        #1 rst_b_i = 1'b0;
        strap = ~strap;
        base = strap ? 'h4e : 'h2e;
        model_reset();
        repeat (5) @(posedge clock_i);
        #1 rst_b_i = 1'b1;
        repeat (3) @(posedge clock_i);
        port_read(0, 0);
        check_outputs();
        index_write('h07);
        port_read(1, 0);
        $display("test second reset done");
        // host read-modify-write of the wake bit, then a plain full write
        data_write(3);
        index_write('h70);
        data_write('h05);
        host.get(16'(base + 1), d, v);
        `chk(d, 8'h05)
        data_write(int'(d) | 'h10);
        port_read(1, 'h15);
        data_write('h07);
        port_read(1, 'h07);
        check_outputs();
        $display("test host update done");
        // accesses outside the port pair are ignored
        host.put(16'(base + 2), 8'($random(seed)));
        host.get(16'(base + 2), d, v);
        `chk(v, 1'b0)
        check_outputs();
        $display("test stray address done");
        complete_run();
    end
endmodule
